//--- logic/pbm_booth_group.sv
// Booth recoding and truncated carry-save reduction of one summand group
`timescale 1ns/1ps
module pbm_booth_group
    import pbm_pkg::*;
#(
    parameter int FIRST = 0,
    parameter int COUNT = 14
) (
    pbm_stage_if.dst bus
);
    localparam int N = COUNT;
    logic [ADD_W-1:0] pp [N];

    // Radix-4 digit of multiplier triplet; swapping signs yields -A*B for iteration
    function automatic logic [2:0] booth_dec(input logic [2:0] t, input logic neg);
        logic [2:0] r;
        r = 3'h0;
        case (t)
            3'h1, 3'h2: r = 3'h1;
            3'h3: r = 3'h2;
            3'h4: r = 3'h6;
            3'h5, 3'h6: r = 3'h5;
            default: r = 3'h0;
        endcase
        if (neg && r != 3'h0) begin
            r[2] = ~r[2];
        end
        return r;
    endfunction : booth_dec

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pp
            localparam int IDX = FIRST + 2 * g;
            wire [2:0] trip = (IDX == 0) ? {bus.mplier[1:0], 1'b0}
                                         : bus.mplier[2*IDX+1 -: 3];
            wire [2:0] dig = booth_dec(trip, bus.neg_sel);
            wire [PPW-1:0] mag = dig[1] ? {{(PPW-FRAC_W-2){bus.mcand[FRAC_W]}},
                                             bus.mcand, 1'b0}
                               : dig[0] ? {{(PPW-FRAC_W-1){bus.mcand[FRAC_W]}}, bus.mcand}
                               : '0;
            wire [PPW-1:0] sgn = dig[2] ? ~mag + PPW'(1) : mag;
            wire [PROD_W+1:0] full = (PROD_W+2)'({{(PROD_W+2-PPW){sgn[PPW-1]}}, sgn})
                                     << (2 * IDX);
            // Sign extension handled by the boundary slice, array stays 64 wide
            assign pp[g] = full[PROD_W-1:TRUNC_W];
        end
    endgenerate

    // Columns below the kept 64 are dropped with no compensation
    always_comb begin
        logic [ADD_W-1:0] s;
        logic [ADD_W-1:0] c;
        logic [ADD_W-1:0] t;
        s = '0;
        c = '0;
        t = '0;
        for (int k = 0; k < N; k++) begin
            t = s ^ c ^ pp[k];
            c = ((s & c) | (s & pp[k]) | (c & pp[k])) << 1;
            s = t;
        end
        bus.sum = s;
        bus.carry = c;
    end
endmodule : pbm_booth_group

//--- logic/pbm_multiplier.sv
// Three-cycle pipelined Booth multiplier with truncated array and late-select rounding
// Contract
// - Fixed three-cycle latency for all modes
// - Radix-4 Booth, 53 summands become 27
// - Two summand halves from shared recoding per cycle
// - Two group partial sums merged by CSA
// - Drop lowest 42 columns, 64-bit adders
// - No compensation for truncated columns
// - Two concurrent rounded sums, half and quarter lsb
// - Select doubled quarter sum when in low range
// - Rounded product fraction never reaches one
// - Recode and reduce during cycle two
// - CSA merge then final add, cycle three
// - Late mux drives result at cycle four
// - Integer operands from high bus halves
// - Integer low product word on high result half
// - Fractions unsigned with zero sign, integers signed
// - Sign extension at boundaries, array not widened
// - Iteration swaps positive and negative Booth selections
// - Iteration adds two by dropping high bits
// - Iteration picks half sum when quarter normalized
`timescale 1ns/1ps
module pbm_multiplier
    import pbm_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_valid,
    input wire pbm_mode_t i_mode,
    input wire logic [BUS_W-1:0] i_src_a,
    input wire logic [BUS_W-1:0] i_src_b,
    input wire logic [EXP_W-1:0] i_exp,
    output logic o_valid,
    output pbm_mode_t o_mode,
    output logic [BUS_W-1:0] o_result,
    output logic [EXP_W-1:0] o_exp
);
    // Stage 1: operands captured
    logic v1_ff;
    pbm_mode_t m1_ff;
    logic [FRAC_W:0] mcand1_ff;
    logic [FRAC_W+1:0] mplier1_ff;
    logic [EXP_W-1:0] e1_ff;
    // Stage 2: both groups reduced
    logic v2_ff;
    pbm_mode_t m2_ff;
    logic [EXP_W-1:0] e2_ff;
    logic [ADD_W-1:0] s_odd_ff, c_odd_ff, s_even_ff, c_even_ff;
    // Stage 3: result register
    logic v3_ff;
    pbm_mode_t m3_ff;
    logic [BUS_W-1:0] r3_ff;
    logic [EXP_W-1:0] e3_ff;

    // Operand placement per mode
    wire is_int = (i_mode == PBM_MODE_IMUL);
    wire [INT_W-1:0] int_a = i_src_a[BUS_W-1 -: INT_W];
    wire [INT_W-1:0] int_b = i_src_b[BUS_W-1 -: INT_W];
    // Integers sit in the upper fraction region so that the whole 64-bit product
    // lands in the kept columns; below the truncation line it would be lost
    localparam int INT_POS = TRUNC_W / 2;
    wire [FRAC_W:0] nxt_mcand = is_int
        ? {{(FRAC_W+1-INT_W-INT_POS){int_a[INT_W-1]}}, int_a, {INT_POS{1'b0}}}
        : {1'b0, 1'b1, i_src_a[FRAC_W-2:0]};
    wire [FRAC_W+1:0] nxt_mplier = is_int
        ? {{(FRAC_W+2-INT_W-INT_POS){int_b[INT_W-1]}}, int_b, {INT_POS{1'b0}}}
        : {2'b00, 1'b1, i_src_b[FRAC_W-2:0]};

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            v1_ff <= 1'b0;
            m1_ff <= PBM_MODE_NONE;
            mcand1_ff <= '0;
            mplier1_ff <= '0;
            e1_ff <= '0;
        end else begin
            v1_ff <= i_valid;
            m1_ff <= i_mode;
            mcand1_ff <= nxt_mcand;
            mplier1_ff <= nxt_mplier;
            e1_ff <= i_exp;
        end
    end

    // Odd and even summand groups share one recoding function; each group
    // gets its own instance since a single clock has no half-cycle to reuse
    pbm_stage_if odd_if ();
    pbm_stage_if even_if ();
    wire iter1 = (m1_ff == PBM_MODE_ITER);
    assign odd_if.mcand = mcand1_ff;
    assign odd_if.mplier = mplier1_ff;
    assign odd_if.neg_sel = iter1;
    assign even_if.mcand = mcand1_ff;
    assign even_if.mplier = mplier1_ff;
    assign even_if.neg_sel = iter1;

    // Digits 0,2,4.. form one group and 1,3,5.. the other, 27 in total
    pbm_booth_group #(.FIRST(0), .COUNT(HALF_BOOTH)) u_odd (.bus(odd_if));
    pbm_booth_group #(.FIRST(1), .COUNT(NUM_BOOTH - HALF_BOOTH))
        u_even (.bus(even_if));

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            v2_ff <= 1'b0;
            m2_ff <= PBM_MODE_NONE;
            e2_ff <= '0;
            s_odd_ff <= '0;
            c_odd_ff <= '0;
            s_even_ff <= '0;
            c_even_ff <= '0;
        end else begin
            v2_ff <= v1_ff;
            m2_ff <= m1_ff;
            e2_ff <= e1_ff;
            s_odd_ff <= odd_if.sum;
            c_odd_ff <= odd_if.carry;
            s_even_ff <= even_if.sum;
            c_even_ff <= even_if.carry;
        end
    end

    // Cycle three: merge the two groups down to two partial sums
    wire [ADD_W-1:0] m_s1 = s_odd_ff ^ c_odd_ff ^ s_even_ff;
    wire [ADD_W-1:0] m_c1 = ((s_odd_ff & c_odd_ff) | (s_odd_ff & s_even_ff)
                            | (c_odd_ff & s_even_ff)) << 1;
    wire [ADD_W-1:0] m_s = m_s1 ^ m_c1 ^ c_even_ff;
    wire [ADD_W-1:0] m_c = ((m_s1 & m_c1) | (m_s1 & c_even_ff)
                            | (m_c1 & c_even_ff)) << 1;
    wire iter2 = (m2_ff == PBM_MODE_ITER);
    wire int2 = (m2_ff == PBM_MODE_IMUL);

    // Rounding bits ride in an extra carry-save slot so both adds run side by side
    wire [ADD_W-1:0] rs_h = m_s ^ m_c ^ RND_HALF;
    wire [ADD_W-1:0] rc_h = ((m_s & m_c) | (m_s & RND_HALF) | (m_c & RND_HALF)) << 1;
    wire [ADD_W-1:0] rs_q = m_s ^ m_c ^ RND_QTR;
    wire [ADD_W-1:0] rc_q = ((m_s & m_c) | (m_s & RND_QTR) | (m_c & RND_QTR)) << 1;
    wire [ADD_W-1:0] sum_h = rs_h + rc_h;
    wire [ADD_W-1:0] sum_q = rs_q + rc_q;
    wire [ADD_W-1:0] sum_i = m_s + m_c;

    // Iteration: -R*D plus two keeps only the bits below 2^1 weight; the top
    // kept column is 2^-1 times two, so discarding the overflow already adds two
    wire [ADD_W-1:0] it_h = sum_h;
    wire [ADD_W-1:0] it_q = sum_q;
    wire q_low = ~sum_q[ADD_W-1] & sum_q[COL_HALF];
    wire q_norm = sum_q[ADD_W-1];

    // Result fraction is the 52 bits below the leading one, exponent adjusted
    wire [BUS_W-1:0] frac_h = {12'h000, sum_h[ADD_W-2 -: FRAC_W-1]};
    wire [BUS_W-1:0] frac_q = {12'h000, sum_q[COL_HALF-1 -: FRAC_W-1]};
    wire [BUS_W-1:0] itr_h = {12'h000, it_h[ADD_W-2 -: FRAC_W-1]};
    wire [BUS_W-1:0] itr_q = {12'h000, it_q[COL_HALF-1 -: FRAC_W-1]};
    wire pick_q = iter2 ? ~q_norm : q_low;
    wire [BUS_W-1:0] nxt_result = int2 ? {sum_i[INT_W-1:0], {INT_W{1'b0}}}
                                : iter2 ? (pick_q ? itr_q : itr_h)
                                : (pick_q ? frac_q : frac_h);
    wire [EXP_W-1:0] nxt_exp = pick_q ? e2_ff - EXP_ONE : e2_ff;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            v3_ff <= 1'b0;
            m3_ff <= PBM_MODE_NONE;
            r3_ff <= '0;
            e3_ff <= '0;
        end else begin
            v3_ff <= v2_ff;
            m3_ff <= m2_ff;
            r3_ff <= nxt_result;
            e3_ff <= nxt_exp;
        end
    end

    assign o_valid = v3_ff;
    assign o_mode = m3_ff;
    assign o_result = r3_ff;
    assign o_exp = e3_ff;

    property p_latency;
        @(posedge i_clk) disable iff (!i_resetn)
        i_valid |-> ##3 o_valid;
    endproperty
    a_latency: assert property (p_latency) else $error("latency not three");

    property p_mode_carry;
        @(posedge i_clk) disable iff (!i_resetn)
        i_valid ##3 1'b1 |-> o_mode == $past(i_mode, 3);
    endproperty
    a_mode_carry: assert property (p_mode_carry) else $error("mode lost");

    property p_int_low;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_valid && i_mode == PBM_MODE_IMUL) |-> ##3
        o_result[BUS_W-1 -: INT_W] == INT_W'($past(int_a, 3) * $past(int_b, 3));
    endproperty
    a_int_low: assert property (p_int_low) else $error("int product wrong");

    property p_int_lowhalf;
        @(posedge i_clk) disable iff (!i_resetn)
        (o_valid && o_mode == PBM_MODE_IMUL) |-> o_result[INT_W-1:0] == '0;
    endproperty
    a_int_lowhalf: assert property (p_int_lowhalf) else $error("low half");

    property p_exp_fmul;
        @(posedge i_clk) disable iff (!i_resetn)
        (i_valid && i_mode == PBM_MODE_FMUL) |-> ##3
        (o_exp == $past(i_exp, 3) || o_exp == $past(i_exp, 3) - EXP_ONE);
    endproperty
    a_exp_fmul: assert property (p_exp_fmul) else $error("exponent");

    property p_no_one;
        @(posedge i_clk) disable iff (!i_resetn)
        (v2_ff && m2_ff == PBM_MODE_FMUL && !pick_q) |-> sum_h[ADD_W-1];
    endproperty
    a_no_one: assert property (p_no_one) else $error("unnormalized");

    property p_sel;
        @(posedge i_clk) disable iff (!i_resetn)
        (v2_ff && iter2) |=> (o_exp == $past(e2_ff)) == $past(q_norm);
    endproperty
    a_sel: assert property (p_sel) else $error("iteration select");

    property p_round_gap;
        @(posedge i_clk) disable iff (!i_resetn)
        v2_ff |-> (sum_h - sum_q) == (RND_HALF - RND_QTR);
    endproperty
    a_round_gap: assert property (p_round_gap) else $error("rounding");

    c_fmul: cover property (@(posedge i_clk) o_valid && o_mode == PBM_MODE_FMUL);
    c_imul: cover property (@(posedge i_clk) o_valid && o_mode == PBM_MODE_IMUL);
    c_iter: cover property (@(posedge i_clk) o_valid && o_mode == PBM_MODE_ITER);
    c_b2b: cover property (@(posedge i_clk) i_valid [*3]);
endmodule : pbm_multiplier

//--- logic/pbm_pkg.sv
// Package for the pipelined Booth multiplier: widths, modes and phase constants
package pbm_pkg;
    localparam int FRAC_W = 53;
    localparam int NUM_SUMMANDS = 53;
    localparam int NUM_BOOTH = 27;
    localparam int HALF_BOOTH = 14;
    localparam int PROD_W = 106;
    localparam int TRUNC_W = 42;
    localparam int ADD_W = 64;
    localparam int EXP_W = 11;
    localparam int INT_W = 32;
    localparam int BUS_W = 64;
    localparam int LATENCY = 3;
    localparam int PPW = 66;
    localparam logic [EXP_W-1:0] EXP_ONE = 11'h001;
    // Weight of one result lsb inside the kept 64 columns (product bit 53 -> column 11)
    localparam int LSB_COL = 11;
    localparam logic [ADD_W-1:0] RND_HALF = 64'h0000_0000_0000_0400;
    localparam logic [ADD_W-1:0] RND_QTR = 64'h0000_0000_0000_0200;
    // Top two kept columns: product bit 105 is column 63, bit 104 column 62
    localparam int COL_HALF = 62;
    localparam int COL_QTR = 61;
    typedef enum logic [1:0] {
        PBM_MODE_FMUL,
        PBM_MODE_IMUL,
        PBM_MODE_ITER,
        PBM_MODE_NONE
    } pbm_mode_t;
endpackage : pbm_pkg

//--- logic/pbm_stage_if.sv
// Interface carrying one pipeline stage's payload between the top and the reducer
`timescale 1ns/1ps
interface pbm_stage_if;
    import pbm_pkg::*;
    logic [pbm_pkg::FRAC_W:0] mcand;
    logic [pbm_pkg::FRAC_W+1:0] mplier;
    logic neg_sel;
    logic [pbm_pkg::ADD_W-1:0] sum;
    logic [pbm_pkg::ADD_W-1:0] carry;
    modport src (output mcand, output mplier, output neg_sel, input sum, input carry);
    modport dst (input mcand, input mplier, input neg_sel, output sum, output carry);
endinterface : pbm_stage_if

//--- verification/pbm_src_model.sv
// Operand source and control model feeding the multiplier
`timescale 1ns/1ps
module pbm_src_model
    import pbm_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    output logic o_valid,
    output pbm_mode_t o_mode,
    output logic [BUS_W-1:0] o_src_a,
    output logic [BUS_W-1:0] o_src_b,
    output logic [EXP_W-1:0] o_exp
);
    logic [140:0] req_q[$];
    logic [140:0] cur;
    task push(input pbm_mode_t m, input logic [63:0] a, input logic [63:0] b,
              input logic [EXP_W-1:0] e);
        req_q.push_back({m, a, b, e});
    endtask : push
    initial begin
        o_valid = 1'b0;
        o_mode = PBM_MODE_NONE;
        o_src_a = '0;
        o_src_b = '0;
        o_exp = '0;
    end
    // Mode travels with every operand pair, one request per edge
    always @(posedge i_clk) begin
        if (i_resetn && req_q.size() > 0) begin
            cur = req_q.pop_front();
            o_valid <= 1'b1;
            o_mode <= pbm_mode_t'(cur[140:139]);
            o_src_a <= cur[138:75];
            o_src_b <= cur[74:11];
            o_exp <= cur[10:0];
        end else begin
            // Idle buses flip so stale operands never pass for held ones
            o_valid <= 1'b0;
            o_mode <= PBM_MODE_NONE;
            o_src_a <= ~o_src_a;
            o_src_b <= ~o_src_b;
            o_exp <= ~o_exp;
        end
    end
endmodule : pbm_src_model

//--- verification/pbm_tb.sv
// Self-checking bench for the pipelined Booth multiplier
`timescale 1ns/1ps
module testbench;
    import pbm_pkg::*;
    logic i_clk;
    logic i_resetn;
    logic rq_v;
    pbm_mode_t rq_m;
    logic [63:0] rq_a;
    logic [63:0] rq_b;
    logic [EXP_W-1:0] rq_e;
    logic o_valid;
    pbm_mode_t o_mode;
    logic [63:0] o_result;
    logic [EXP_W-1:0] o_exp;
    int fails;
    int checks_done;
    logic [63:0] want_r[$];
    logic [EXP_W-1:0] want_e[$];
    pbm_mode_t want_m[$];

    pbm_src_model src_u (.i_clk(i_clk), .i_resetn(i_resetn), .o_valid(rq_v), .o_mode(rq_m),
        .o_src_a(rq_a), .o_src_b(rq_b), .o_exp(rq_e));
    pbm_multiplier dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_valid(rq_v), .i_mode(rq_m),
        .i_src_a(rq_a), .i_src_b(rq_b), .i_exp(rq_e), .o_valid(o_valid), .o_mode(o_mode),
        .o_result(o_result), .o_exp(o_exp));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    task cmp(input string what, input logic [63:0] want, input logic [63:0] seen);
        checks_done++;
        if (seen !== want) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, want, seen);
        end
    endtask : cmp

    // Truncated columns may leave the fraction one lsb off exact rounding
    task cmp_frac(input logic [63:0] want, input logic [63:0] seen, input bit up);
        checks_done++;
        if (seen !== want && seen !== want - 64'h1 && !(up && seen === want + 64'h1)) begin
            fails++;
            $display("mismatch fraction expected %h seen %h", want, seen);
        end
    endtask : cmp_frac

    task automatic add(input pbm_mode_t m, input logic [63:0] a, input logic [63:0] b,
                       input logic [EXP_W-1:0] e);
        logic [127:0] q;
        longint sp;
        src_u.push(m, a, b, e);
        want_m.push_back(m);
        want_e.push_back(e);
        sp = longint'(signed'(a[63:32])) * longint'(signed'(b[63:32]));
        q = {75'h0, 1'b1, a[51:0]} * {75'h0, 1'b1, b[51:0]};
        if (m == PBM_MODE_ITER) begin
            q = (128'h1 << 106) - q;
        end
        if (q[105]) begin
            q = (q + (128'h1 << 52)) >> 53;
        end else begin
            q = (q + (128'h1 << 51)) >> 52;
            want_e[$] = e - 11'h1;
        end
        want_r.push_back(m == PBM_MODE_IMUL ? {sp[31:0], 32'h0} : {12'h0, q[51:0]});
    endtask : add

    task drain(input string name);
        int n;
        n = want_r.size();
        repeat (3) begin
            @(posedge i_clk);
            #1;
            cmp("early valid", 64'h0, {63'h0, o_valid});
        end
        for (int k = 0; k < n; k++) begin
            @(posedge i_clk);
            #1;
            cmp("valid", 64'h1, {63'h0, o_valid});
            cmp("mode", {62'h0, want_m[0]}, {62'h0, o_mode});
            if (want_m[0] == PBM_MODE_IMUL) begin
                cmp("int product", want_r[0], o_result);
            end else begin
                cmp_frac(want_r[0], o_result, want_m[0] == PBM_MODE_ITER);
                cmp("exponent", {53'h0, want_e[0]}, {53'h0, o_exp});
            end
            void'(want_r.pop_front());
            void'(want_e.pop_front());
            void'(want_m.pop_front());
        end
        @(posedge i_clk);
        #1;
        cmp("late valid", 64'h0, {63'h0, o_valid});
        $display("test %s done", name);
    endtask : drain

    task t_abort;
        add(PBM_MODE_FMUL, 64'h0, 64'h0, 11'h400);
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b0;
        repeat (4) begin
            @(posedge i_clk);
            #1;
            cmp("valid in reset", 64'h0, {63'h0, o_valid});
            cmp("result in reset", 64'h0, o_result);
        end
        @(posedge i_clk);
        i_resetn <= 1'b1;
        @(posedge i_clk);
        #1;
        cmp("valid after reset", 64'h0, {63'h0, o_valid});
        want_r.delete();
        want_e.delete();
        want_m.delete();
        $display("test abort done");
    endtask : t_abort

    task stop_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (20000) @(posedge i_clk);
        fails++;
        stop_test();
    end

    initial begin
        fails = 0;
        checks_done = 0;
        i_resetn = 1'b0;
        repeat (5) @(posedge i_clk);
        #1;
        cmp("reset mode", {62'h0, PBM_MODE_NONE}, {62'h0, o_mode});
        cmp("reset result", 64'h0, o_result);
        @(posedge i_clk);
        i_resetn <= 1'b1;
        // Back-to-back floating products: low range, largest, high range, odd lsb
        add(PBM_MODE_FMUL, 64'h0, 64'h0, 11'h400);
        add(PBM_MODE_FMUL, 64'hf_ffff_ffff_ffff, 64'hf_ffff_ffff_ffff, 11'h400);
        add(PBM_MODE_FMUL, 64'h8_0000_0000_0000, 64'h8_0000_0000_0000, 11'h3ff);
        add(PBM_MODE_FMUL, 64'h1, 64'h0, 11'h401);
        drain("fmul");
        // Low bus halves carry junk that integer mode must ignore
        add(PBM_MODE_IMUL, 64'hffff_fffd_1234_5678, 64'h0000_0007_dead_beef, 11'h0);
        add(PBM_MODE_IMUL, 64'h8000_0000_0000_0000, 64'h8000_0000_ffff_ffff, 11'h0);
        add(PBM_MODE_IMUL, 64'h7fff_ffff_0000_0000, 64'h7fff_ffff_0000_0000, 11'h0);
        add(PBM_MODE_NONE, 64'h8_0000_0000_0000, 64'h0, 11'h3ff);
        drain("imul");
        // Iteration step with product either side of two
        add(PBM_MODE_ITER, 64'h5_5555_5555_5555, 64'h8_0000_0000_0000, 11'h401);
        add(PBM_MODE_ITER, 64'h5_5555_5555_5556, 64'h8_0000_0000_0000, 11'h401);
        add(PBM_MODE_FMUL, 64'h0, 64'h0, 11'h400);
        drain("iter");
        t_abort();
        stop_test();
    end
endmodule : testbench
